//--- logic/dsc_consts.svh
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH

`define DSC_SHIFT_BITS     32
`define DSC_WORD_BITS      24
`define DSC_DATA_BITS      16
`define DSC_FIELD_BITS     4
`define DSC_CMD_MSB        23
`define DSC_CMD_LSB        20
`define DSC_ADDR_MSB       19
`define DSC_ADDR_LSB       16
`define DSC_DATA_MSB       15
`define DSC_DATA_LSB       0

`define DSC_CMD_WRITE      4'h0
`define DSC_CMD_UPDATE     4'h1
`define DSC_CMD_WRITE_ALL  4'h2
`define DSC_CMD_WRITE_UPD  4'h3
`define DSC_CMD_POWER_DOWN 4'h4
`define DSC_CMD_NOP        4'hf

`define DSC_ADDR_A         4'h0
`define DSC_ADDR_B         4'h1
`define DSC_ADDR_ALL       4'hf

`define DSC_CODE_RESET     16'h0000
`define DSC_PD_RESET       1'b0

`endif

//--- logic/dsc_pkg.sv
package dsc_pkg;

  typedef enum logic [1:0] {
    DSC_ST_IDLE   = 2'b01,
    DSC_ST_ACTIVE = 2'b10
  } dsc_state_e;

  typedef struct packed {
    logic [15:0] code;
    logic        powered_down;
  } dsc_chan_s;

  typedef struct packed {
    logic [3:0]  command_code_field;
    logic [3:0]  channel_address_field;
    logic [15:0] data;
  } dsc_word_s;

endpackage

//--- logic/dsc_serial_port.sv
`timescale 1ns/1ps
`include "dsc_consts.svh"

module dsc_serial_port
  import dsc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        serial_clk,
  input  wire logic        select_and_load,
  input  wire logic        serial_data_in,
  output dsc_chan_s        chan_a,
  output dsc_chan_s        chan_b,
  output logic [15:0]      input_reg_a,
  output logic [15:0]      input_reg_b,
  output logic             exec_pulse
);

  // Serial clock domain. The shift register needs no reset: its contents are only
  // consumed once a frame ends with select returning high; the number of bits clocked in is not checked.
  logic [`DSC_SHIFT_BITS-1:0] shift_q;

  always_ff @(posedge serial_clk) begin
    if (!select_and_load) begin
      shift_q <= {shift_q[`DSC_SHIFT_BITS-2:0], serial_data_in};
    end
  end

  // System clock domain: select is a pin, so it passes three flip-flops and a
  // change counts once the second and third agree.
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic cs_level_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= select_and_load;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  wire cs_agree = (cs_s2_q == cs_s3_q);
  wire cs_level_d = cs_agree ? cs_s3_q : cs_level_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_level_q <= 1'b1;
    end else begin
      cs_level_q <= cs_level_d;
    end
  end

  // A frame is only executed after select has been seen low, so the high level
  // present at power-up never triggers a spurious command.
  dsc_state_e state_q;
  dsc_state_e state_d;
  wire        load_edge;

  assign load_edge = (state_q == DSC_ST_ACTIVE) && cs_level_q;

  always_comb begin
    case (state_q)
      DSC_ST_IDLE:   state_d = cs_level_q ? DSC_ST_IDLE : DSC_ST_ACTIVE;
      DSC_ST_ACTIVE: state_d = cs_level_q ? DSC_ST_IDLE : DSC_ST_ACTIVE;
      default:       state_d = DSC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= DSC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // The shift register is quiet while select is high, so it is read directly here.
  // This relies on the host keeping select high long enough for the synchroniser.
  dsc_word_s word;
  assign word = dsc_word_s'(shift_q[`DSC_WORD_BITS-1:0]);

  function automatic logic [1:0] chan_select(input logic [3:0] addr);
    case (addr)
      `DSC_ADDR_A:   chan_select = 2'b01;
      `DSC_ADDR_B:   chan_select = 2'b10;
      `DSC_ADDR_ALL: chan_select = 2'b11;
      default:       chan_select = 2'b00;
    endcase
  endfunction

  wire [1:0] sel = chan_select(word.channel_address_field);
  wire [3:0] cmd = word.command_code_field;

  wire is_write = (cmd == `DSC_CMD_WRITE) || (cmd == `DSC_CMD_WRITE_ALL) ||
                  (cmd == `DSC_CMD_WRITE_UPD);
  wire is_pd    = (cmd == `DSC_CMD_POWER_DOWN);

  wire [1:0] wr_mask  = (load_edge && is_write) ? sel : 2'b00;
  wire [1:0] upd_mask = !load_edge                        ? 2'b00 :
                        (cmd == `DSC_CMD_UPDATE)          ? sel   :
                        (cmd == `DSC_CMD_WRITE_ALL)       ? 2'b11 :
                        (cmd == `DSC_CMD_WRITE_UPD)       ? sel   :
                                                            2'b00;
  wire [1:0] pd_mask  = (load_edge && is_pd) ? sel : 2'b00;

  // Update takes the input register value after this command's write, so a
  // write-and-update lands the new data in the same cycle.
  logic [15:0] in_q   [2];
  logic [15:0] code_q [2];
  logic [1:0]  pd_q;
  logic [15:0] in_d   [2];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      in_d[i] = wr_mask[i] ? word.data : in_q[i];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 2; i++) begin
        in_q[i]   <= `DSC_CODE_RESET;
        code_q[i] <= `DSC_CODE_RESET;
      end
      pd_q <= {2{`DSC_PD_RESET}};
    end else begin
      for (int i = 0; i < 2; i++) begin
        in_q[i] <= in_d[i];
        if (upd_mask[i]) begin
          code_q[i] <= in_d[i];
          pd_q[i]   <= 1'b0;
        end else if (pd_mask[i]) begin
          pd_q[i]   <= 1'b1;
        end
      end
    end
  end

  logic exec_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      exec_q <= 1'b0;
    end else begin
      exec_q <= load_edge;
    end
  end

  assign chan_a      = '{code: code_q[0], powered_down: pd_q[0]};
  assign chan_b      = '{code: code_q[1], powered_down: pd_q[1]};
  assign input_reg_a = in_q[0];
  assign input_reg_b = in_q[1];
  assign exec_pulse  = exec_q;

endmodule // dsc_serial_port

//--- sim/dsc_host_model.sv
`timescale 1ns/1ps
module dsc_host_model (
  output logic serial_clk,
  output logic select_and_load,
  output logic serial_data_in
);
  initial begin
    serial_clk = 0;
    select_and_load = 1;
    serial_data_in = 0;
  end
  // The link clock only runs inside a frame; the data line flips after release.
  task automatic send(input logic [31:0] w, input int n);
    #7 select_and_load = 0;
    for (int i = n - 1; i >= 0; i--) begin
      #20 serial_data_in = w[i];
      #20 serial_clk = 1;
      #40 serial_clk = 0;
    end
    #20 select_and_load = 1;
    serial_data_in = ~serial_data_in;
    #200;
  endtask
endmodule // dsc_host_model

//--- sim/dsc_serial_port_asserts.sv
`timescale 1ns/1ps
module dsc_serial_port_asserts
  import dsc_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input dsc_chan_s        chan_a,
  input dsc_chan_s        chan_b,
  input wire logic [15:0] input_reg_a,
  input wire logic [15:0] input_reg_b,
  input wire logic        exec_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_PULSE: assert property (exec_pulse |=> !exec_pulse) else $error("pulse too long");
  AST_RST: assert property (disable iff (1'b0) sys_rst |=> chan_a == '0 && chan_b == '0)
    else $error("reset values");
  AST_IRA: assert property (!$stable(input_reg_a) |-> exec_pulse) else $error("stray a write");
  AST_IRB: assert property (!$stable(input_reg_b) |-> exec_pulse) else $error("stray b write");
  AST_UPA: assert property (!$stable(chan_a.code) |-> chan_a.code == input_reg_a && exec_pulse)
    else $error("bad a update");
  AST_UPB: assert property (!$stable(chan_b.code) |-> chan_b.code == input_reg_b && exec_pulse)
    else $error("bad b update");
  AST_PUA: assert property ($fell(chan_a.powered_down) |-> chan_a.code == input_reg_a) else $error("a up");
  AST_PUB: assert property ($fell(chan_b.powered_down) |-> chan_b.code == input_reg_b) else $error("b up");
  cover property (exec_pulse);
  cover property ($rose(chan_a.powered_down));
  cover property ($fell(chan_b.powered_down));
endmodule // dsc_serial_port_asserts

bind dsc_serial_port dsc_serial_port_asserts chk_u (.clk(clk), .sys_rst(sys_rst), .chan_a(chan_a),
  .chan_b(chan_b), .input_reg_a(input_reg_a), .input_reg_b(input_reg_b), .exec_pulse(exec_pulse));

//--- sim/dual_dac_serial_command_port_test.sv
`timescale 1ns/1ps
module dual_dac_serial_command_port_test;
  import dsc_pkg::*;
  logic        clk = 0;
  logic        sys_rst = 1;
  wire         serial_clk, select_and_load, serial_data_in;
  dsc_chan_s   chan_a, chan_b;
  logic [15:0] input_reg_a, input_reg_b;
  logic        exec_pulse;
  int          miscompares = 0, tests_run = 0, cycles = 0, exec_seen = 0;
  always #2.5 clk = ~clk;
  // Every executed frame, reserved codes included, must give exactly one pulse.
  always @(posedge clk) begin
    if (exec_pulse === 1'b1) exec_seen++;
  end
  dsc_host_model host_u (.serial_clk(serial_clk), .select_and_load(select_and_load),
    .serial_data_in(serial_data_in));
  dsc_serial_port dut_u (.clk(clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
    .select_and_load(select_and_load), .serial_data_in(serial_data_in), .chan_a(chan_a), .chan_b(chan_b),
    .input_reg_a(input_reg_a), .input_reg_b(input_reg_b), .exec_pulse(exec_pulse));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task pulses(input logic [15:0] n);
    chk(16'(exec_seen), n);
  endtask
  task cmd(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
    host_u.send({8'h00, c, a, d}, 24);
  endtask
  task all(input logic [15:0] ia, ib, ca, cb, input logic [1:0] pd);
    chk(input_reg_a, ia);
    chk(input_reg_b, ib);
    chk(chan_a.code, ca);
    chk(chan_b.code, cb);
    chk({14'h0, chan_a.powered_down, chan_b.powered_down}, {14'h0, pd});
  endtask
  task t_basic;
    all(16'h0, 16'h0, 16'h0, 16'h0, 2'b00);
    cmd(4'h0, 4'h0, 16'h1234);
    all(16'h1234, 16'h0, 16'h0, 16'h0, 2'b00);
    cmd(4'h1, 4'h0, 16'hdead);
    all(16'h1234, 16'h0, 16'h1234, 16'h0, 2'b00);
    pulses(16'd2);
    $display("t_basic done");
  endtask
  task t_power;
    cmd(4'h4, 4'hf, 16'hffff);
    all(16'h1234, 16'h0, 16'h1234, 16'h0, 2'b11);
    cmd(4'h2, 4'h1, 16'h5678);
    all(16'h1234, 16'h5678, 16'h1234, 16'h5678, 2'b00);
    pulses(16'd4);
    $display("t_power done");
  endtask
  task t_long;
    host_u.send({8'hff, 4'h3, 4'h1, 16'h9abc}, 32);
    all(16'h1234, 16'h9abc, 16'h1234, 16'h9abc, 2'b00);
    pulses(16'd5);
    $display("t_long done");
  endtask
  task t_nop;
    cmd(4'hf, 4'h0, 16'haaaa);
    cmd(4'h0, 4'h2, 16'hbbbb);
    cmd(4'h7, 4'h1, 16'hcccc);
    all(16'h1234, 16'h9abc, 16'h1234, 16'h9abc, 2'b00);
    pulses(16'd8);
    $display("t_nop done");
  endtask
  task t_reset;
    @(posedge clk);
    #1 sys_rst = 1;
    repeat (2) @(posedge clk);
    #1 sys_rst = 0;
    repeat (8) @(posedge clk);
    all(16'h0, 16'h0, 16'h0, 16'h0, 2'b00);
    cmd(4'h3, 4'h0, 16'h4321);
    all(16'h4321, 16'h0, 16'h4321, 16'h0, 2'b00);
    pulses(16'd9);
    $display("t_reset done");
  endtask
  task results;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 sys_rst = 0;
    repeat (8) @(posedge clk);
    t_basic();
    t_power();
    t_long();
    t_nop();
    t_reset();
    results();
  end
endmodule // dual_dac_serial_command_port_test
